// [design/dsh_map.svh]
`ifndef DSH_MAP_SVH
`define DSH_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DSH_OFF_DRV_PROT     8'h00
`define DSH_OFF_SYS_PROT     8'h04
`define DSH_OFF_STAT1        8'h08
`define DSH_OFF_STAT2        8'h0C
`define DSH_OFF_STAT3        8'h10
`define DSH_OFF_ACT_SEQ      8'h14
`define DSH_OFF_RSVD_A       8'h18
`define DSH_OFF_RSVD_B       8'h1C
`define DSH_OFF_IRQ_STATUS   8'h20
`define DSH_OFF_IRQ_MASK     8'h24

// ----------------------------------------
// Live bits of each history word
// ----------------------------------------
`define DSH_LIVE_DRV_PROT    16'h007F
`define DSH_LIVE_SYS_PROT    16'h3FFF
`define DSH_LIVE_STAT1       16'hFFFF
`define DSH_LIVE_STAT2       16'hF7FF
`define DSH_LIVE_STAT3       16'h1FC0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define DSH_RST_HIST         16'h0000
`define DSH_RST_IRQ          6'h00
`define DSH_SEQ_DYNAMIC      8'hFE
`define DSH_SEQ_NONE         8'hFF
`define DSH_RESP_OKAY        2'h0
`define DSH_RESP_SLVERR      2'h2

`endif

// [design/dsh_pkg.sv]
package dsh_pkg;
    typedef logic [15:0] dsh_word_type;
    typedef logic [7:0]  dsh_byte_type;
    typedef logic [5:0]  dsh_irq_type;
endpackage

// [design/dsh_hist_if.sv]
`timescale 1ns/100ps
interface dsh_hist_if;
    dsh_pkg::dsh_word_type clr;
    dsh_pkg::dsh_word_type hist;
    logic                  fresh;

    modport bank (input clr, output hist, output fresh);
    modport ctrl (output clr, input hist, input fresh);
endinterface

// [design/dsh_hist_word.sv]
`timescale 1ns/100ps
`include "dsh_map.svh"
module dsh_hist_word #(
    parameter dsh_pkg::dsh_word_type LIVE_MASK = 16'hFFFF
) (
    input  wire logic                  clock,   // Drive clock
    input  wire logic                  rst_n,   // Async reset, low
    input  wire logic                  ce,      // Clock enable
    input  wire dsh_pkg::dsh_word_type ev,      // Live status bits
    dsh_hist_if.bank                   port     // Clear in, history out
);
    dsh_pkg::dsh_word_type ev_prev_q;
    dsh_pkg::dsh_word_type hist_q;
    dsh_pkg::dsh_word_type fall_w;

    // Active then inactive marks the event
    assign fall_w     = ev_prev_q & ~ev & LIVE_MASK;  // RULE1
    assign port.hist  = hist_q;
    assign port.fresh = |(fall_w & ~hist_q);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ev_prev_q <= `DSH_RST_HIST;
        end else if (ce) begin
            ev_prev_q <= ev & LIVE_MASK;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= `DSH_RST_HIST;  // RULE2
        end else if (ce) begin
            hist_q <= (hist_q & ~port.clr) | fall_w;  // RULE1 RULE3
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_fall_sets;
        ce |=> (($past(fall_w) & ~hist_q) == 16'h0000);
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("fall not recorded"); // RULE1

    property p_no_spurious;
        ce |=> ((hist_q & ~$past(hist_q) & ~$past(fall_w)) == 16'h0000);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("bit set w/o event"); // RULE2

    property p_clear_one;
        ce && (fall_w == 16'h0000) |=> (hist_q == ($past(hist_q) & ~$past(port.clr)));
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("clear not exact"); // RULE3
endmodule

// [design/dsh_seq_enc.sv]
`timescale 1ns/100ps
`include "dsh_map.svh"
module dsh_seq_enc (
    input  wire logic                  clock,    // Drive clock
    input  wire logic                  rst_n,    // Async reset, low
    input  wire logic                  ce,       // Clock enable
    input  wire logic                  active,   // Index running
    input  wire logic                  dynamic,  // Dynamic index running
    input  wire logic [3:0]            index,    // Running index
    output dsh_pkg::dsh_byte_type      code_q,   // Reported sequence byte
    output logic                       chg_q     // Code changed pulse
);
    dsh_pkg::dsh_byte_type code_d;

    always_comb begin
        if (dynamic) begin
            code_d = `DSH_SEQ_DYNAMIC;  // RULE7
        end else if (active) begin
            code_d = {4'h0, index};  // RULE7
        end else begin
            code_d = `DSH_SEQ_NONE;  // RULE8
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= `DSH_SEQ_NONE;
            chg_q  <= 1'b0;
        end else if (ce) begin
            code_q <= code_d;
            chg_q  <= (code_d != code_q);
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_dyn_code;
        ce && dynamic |=> (code_q == 8'hFE);
    endproperty
    a_dyn_code: assert property (p_dyn_code) else $error("dynamic code wrong"); // RULE7

    property p_idx_code;
        ce && active && !dynamic |=> (code_q == {4'h0, $past(index)});
    endproperty
    a_idx_code: assert property (p_idx_code) else $error("index code wrong"); // RULE7

    property p_none_code;
        ce && !active && !dynamic |=> (code_q == 8'hFF);
    endproperty
    a_none_code: assert property (p_none_code) else $error("idle code wrong"); // RULE8
endmodule

// [design/dsh_bank.sv]
// Contract
// (RULE1) Event active then inactive sets history bit
// (RULE2) History bits start cleared after power-up
// (RULE3) Writing one clears only that bit
// (RULE4) Sixteen-bit words, readable, clear-only writes
// (RULE5) Five history words mirror live status layouts
// (RULE6) Drive protection word uses bits 0-6
// (RULE7) Sequence byte: index 0-15 or FE
// (RULE8) Sequence byte FF when no index
// (RULE9) Reserved words, upper sequence byte read zero
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "dsh_map.svh"
module dsh_bank (
    input  wire logic                  clock,            // Drive clock, 50 MHz
    input  wire logic                  rst_n,            // Async reset, low
    input  wire logic                  ce,               // Clock enable
    input  wire dsh_pkg::dsh_word_type drv_prot_events,  // Live drive protection
    input  wire dsh_pkg::dsh_word_type sys_prot_events,  // Live system protection
    input  wire dsh_pkg::dsh_word_type stat1_events,     // Live status 1
    input  wire dsh_pkg::dsh_word_type stat2_events,     // Live status 2
    input  wire dsh_pkg::dsh_word_type stat3_events,     // Live status 3
    input  wire logic                  seq_active,       // Engine runs an index
    input  wire logic                  seq_dynamic,      // Dynamic index active
    input  wire logic [3:0]            seq_index,        // Running index
    input  wire logic [7:0]            s_axi_awaddr,     // Write address
    input  wire logic                  s_axi_awvalid,    // Write address valid
    output logic                       s_axi_awready,    // Write address ready
    input  wire logic [31:0]           s_axi_wdata,      // Write data
    input  wire logic [3:0]            s_axi_wstrb,      // Write strobes
    input  wire logic                  s_axi_wvalid,     // Write data valid
    output logic                       s_axi_wready,     // Write data ready
    output logic [1:0]                 s_axi_bresp,      // Write response
    output logic                       s_axi_bvalid,     // Write response valid
    input  wire logic                  s_axi_bready,     // Write response ready
    input  wire logic [7:0]            s_axi_araddr,     // Read address
    input  wire logic                  s_axi_arvalid,    // Read address valid
    output logic                       s_axi_arready,    // Read address ready
    output logic [31:0]                s_axi_rdata,      // Read data
    output logic [1:0]                 s_axi_rresp,      // Read response
    output logic                       s_axi_rvalid,     // Read data valid
    input  wire logic                  s_axi_rready,     // Read data ready
    output logic                       irq               // Interrupt, high
);
    // ----------------------------------------
    // History words
    // ----------------------------------------
    localparam int NWORD = 5;

    dsh_hist_if            hist_if [NWORD] ();
    dsh_pkg::dsh_word_type ev_w    [NWORD];
    dsh_pkg::dsh_word_type hist_w  [NWORD];
    dsh_pkg::dsh_word_type clr_w   [NWORD];
    logic [NWORD-1:0]      fresh_w;

    function automatic dsh_pkg::dsh_word_type live_mask(input int k);
        case (k)
            0:       live_mask = `DSH_LIVE_DRV_PROT;  // RULE6
            1:       live_mask = `DSH_LIVE_SYS_PROT;
            2:       live_mask = `DSH_LIVE_STAT1;
            3:       live_mask = `DSH_LIVE_STAT2;
            default: live_mask = `DSH_LIVE_STAT3;
        endcase
    endfunction

    assign ev_w[0] = drv_prot_events;  // RULE5
    assign ev_w[1] = sys_prot_events;
    assign ev_w[2] = stat1_events;
    assign ev_w[3] = stat2_events;
    assign ev_w[4] = stat3_events;

    for (genvar g = 0; g < NWORD; g++) begin : g_word
        dsh_hist_word #(
            .LIVE_MASK (live_mask(g))
        ) u_word (
            .clock (clock),
            .rst_n (rst_n),
            .ce    (ce),
            .ev    (ev_w[g]),
            .port  (hist_if[g])
        );
        assign hist_if[g].clr = clr_w[g];
        assign hist_w[g]      = hist_if[g].hist;
        assign fresh_w[g]     = hist_if[g].fresh;
    end

    // ----------------------------------------
    // Active sequence
    // ----------------------------------------
    dsh_pkg::dsh_byte_type seq_code;
    logic                  seq_chg;

    dsh_seq_enc u_seq (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (ce),
        .active  (seq_active),
        .dynamic (seq_dynamic),
        .index   (seq_index),
        .code_q  (seq_code),
        .chg_q   (seq_chg)
    );

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    logic                  awready_q;
    logic                  wready_q;
    logic                  aw_full_q;
    logic                  w_full_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic [7:0]            waddr_q;
    dsh_pkg::dsh_word_type wdata_q;
    logic [1:0]            wstrb_q;
    logic                  wr_go;
    dsh_pkg::dsh_word_type wr_bits;

    assign wr_go   = ce & aw_full_q & w_full_q & ~bvalid_q;
    assign wr_bits = wdata_q & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[7:2] <= `DSH_OFF_IRQ_MASK >> 2);
    endfunction

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            awready_q <= 1'b1;
            aw_full_q <= 1'b0;
            waddr_q   <= 8'h00;
        end else if (ce) begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                aw_full_q <= 1'b1;
                waddr_q   <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end else if (bvalid_q && s_axi_bready) begin
                awready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wready_q <= 1'b1;
            w_full_q <= 1'b0;
            wdata_q  <= 16'h0000;
            wstrb_q  <= 2'b00;
        end else if (ce) begin
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                w_full_q <= 1'b1;
                wdata_q  <= s_axi_wdata[15:0];
                wstrb_q  <= s_axi_wstrb[1:0];
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end else if (bvalid_q && s_axi_bready) begin
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `DSH_RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= mapped(waddr_q) ? `DSH_RESP_OKAY : `DSH_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Writes only clear; reserved and read-only words ignore them
    always_comb begin
        for (int k = 0; k < NWORD; k++) begin
            clr_w[k] = 16'h0000;
        end
        if (wr_go) begin
            unique case (waddr_q[7:2])
                `DSH_OFF_DRV_PROT >> 2: clr_w[0] = wr_bits;  // RULE3 RULE4
                `DSH_OFF_SYS_PROT >> 2: clr_w[1] = wr_bits;  // RULE3
                `DSH_OFF_STAT1 >> 2:    clr_w[2] = wr_bits;  // RULE3
                `DSH_OFF_STAT2 >> 2:    clr_w[3] = wr_bits;  // RULE3
                `DSH_OFF_STAT3 >> 2:    clr_w[4] = wr_bits;  // RULE3
                default: ;  // RULE9
            endcase
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    dsh_pkg::dsh_irq_type irq_stat_q;
    dsh_pkg::dsh_irq_type irq_mask_q;
    logic                 irq_q;
    logic                 wr_stat;
    logic                 wr_mask;

    assign wr_stat = wr_go && (waddr_q[7:2] == 6'(`DSH_OFF_IRQ_STATUS >> 2)) && wstrb_q[0];
    assign wr_mask = wr_go && (waddr_q[7:2] == 6'(`DSH_OFF_IRQ_MASK >> 2)) && wstrb_q[0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= `DSH_RST_IRQ;
        end else if (ce) begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_q[5:0] : 6'h00))
                        | {seq_chg, fresh_w};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= `DSH_RST_IRQ;
        end else if (ce && wr_mask) begin
            irq_mask_q <= wdata_q[5:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_mux;
    logic        ar_hs;

    assign ar_hs = ce & s_axi_arvalid & arready_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (s_axi_araddr[7:2])
            `DSH_OFF_DRV_PROT >> 2:   rd_mux = {16'h0000, hist_w[0]};  // RULE4 RULE5
            `DSH_OFF_SYS_PROT >> 2:   rd_mux = {16'h0000, hist_w[1]};  // RULE5
            `DSH_OFF_STAT1 >> 2:      rd_mux = {16'h0000, hist_w[2]};  // RULE5
            `DSH_OFF_STAT2 >> 2:      rd_mux = {16'h0000, hist_w[3]};  // RULE5
            `DSH_OFF_STAT3 >> 2:      rd_mux = {16'h0000, hist_w[4]};  // RULE5
            `DSH_OFF_ACT_SEQ >> 2:    rd_mux = {24'h00_0000, seq_code};  // RULE7 RULE9
            `DSH_OFF_IRQ_STATUS >> 2: rd_mux = {26'h000_0000, irq_stat_q};
            `DSH_OFF_IRQ_MASK >> 2:   rd_mux = {26'h000_0000, irq_mask_q};
            default:                  rd_mux = 32'h0000_0000;  // RULE9
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `DSH_RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_mux;
                rresp_q   <= mapped(s_axi_araddr) ? `DSH_RESP_OKAY : `DSH_RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                arready_q <= 1'b1;
                rvalid_q  <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign irq           = irq_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_rdata_16;
        rvalid_q |-> (rdata_q[31:16] == 16'h0000);
    endproperty
    a_rdata_16: assert property (p_rdata_16) else $error("upper read bits set"); // RULE4

    property p_read_drv;
        ar_hs && (s_axi_araddr == `DSH_OFF_DRV_PROT) |=> (rdata_q == {16'h0000, $past(hist_w[0])});
    endproperty
    a_read_drv: assert property (p_read_drv) else $error("drive word misread"); // RULE5

    property p_read_stat3;
        ar_hs && (s_axi_araddr == `DSH_OFF_STAT3) |=> (rdata_q == {16'h0000, $past(hist_w[4])});
    endproperty
    a_read_stat3: assert property (p_read_stat3) else $error("status 3 misread"); // RULE5

    property p_drv_rsvd;
        (hist_w[0][15:7] == 9'h000);
    endproperty
    a_drv_rsvd: assert property (p_drv_rsvd) else $error("drive reserved bit set"); // RULE6

    property p_rsvd_zero;
        ar_hs && ((s_axi_araddr == `DSH_OFF_RSVD_A) || (s_axi_araddr == `DSH_OFF_RSVD_B))
            |=> (rdata_q == 32'h0000_0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved reads nonzero"); // RULE9

    property p_seq_upper;
        ar_hs && (s_axi_araddr == `DSH_OFF_ACT_SEQ) |=> (rdata_q[31:8] == 24'h00_0000);
    endproperty
    a_seq_upper: assert property (p_seq_upper) else $error("sequence upper byte set"); // RULE9

    property p_wr_resp;
        wr_go |=> s_axi_bvalid ##0 !s_axi_awready ##0 !s_axi_wready;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");

    property p_irq_level;
        ce && (|(irq_stat_q & irq_mask_q)) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

    property p_rd_unmapped;
        ar_hs && !mapped(s_axi_araddr) |=> (s_axi_rresp == `DSH_RESP_SLVERR);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read accepted");

    property p_ro_write;
        wr_go && (waddr_q[7:2] >= 6'(`DSH_OFF_ACT_SEQ >> 2))
            |-> ((clr_w[0] | clr_w[1] | clr_w[2] | clr_w[3] | clr_w[4]) == 16'h0000);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write cleared history"); // RULE9

    property p_irq_clear;
        wr_stat && wdata_q[0] && !fresh_w[0] |=> !irq_stat_q[0];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
`include "dsh_map.svh"
module tb;
    typedef struct {
        int                    w;
        dsh_pkg::dsh_word_type ev;
        dsh_pkg::dsh_word_type hist;
    } dsh_row_type;
    typedef struct {
        logic                  dyn;
        logic                  act;
        logic [3:0]            idx;
        dsh_pkg::dsh_byte_type code;
    } dsh_seq_row_type;

    // ----------------------------------------
    // Signals and case tables
    // ----------------------------------------
    logic                  clock;
    logic                  rst_n;
    logic                  ce;
    dsh_pkg::dsh_word_type ev [5];
    logic                  seq_active;
    logic                  seq_dynamic;
    logic [3:0]            seq_index;
    logic [7:0]            awaddr;
    logic                  awvalid;
    logic                  awready;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  bready;
    logic [7:0]            araddr;
    logic                  arvalid;
    logic                  arready;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
    logic                  rready;
    logic                  irq;
    int                    err_total;
    int                    comparisons;
    dsh_row_type           rows [5] = '{'{0, 16'hFFFF, 16'h007F}, '{1, 16'hFFFF, 16'h3FFF},
                                        '{2, 16'hFFFF, 16'hFFFF}, '{3, 16'hFFFF, 16'hF7FF},
                                        '{4, 16'hFFFF, 16'h1FC0}};
    dsh_seq_row_type       seqs [4] = '{'{0, 1, 4'h0, 8'h00}, '{0, 1, 4'hF, 8'h0F},
                                        '{1, 1, 4'h5, 8'hFE}, '{0, 0, 4'h7, 8'hFF}};

    dsh_bank DUT (
        .clock(clock), .rst_n(rst_n), .ce(ce),
        .drv_prot_events(ev[0]), .sys_prot_events(ev[1]), .stat1_events(ev[2]),
        .stat2_events(ev[3]), .stat3_events(ev[4]),
        .seq_active(seq_active), .seq_dynamic(seq_dynamic), .seq_index(seq_index),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq)
    );

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge clock);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid && bready) begin
                got = 1'b1;
                bready <= 1'b0;
                check(32'(bresp), 32'(er));
            end
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge clock);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid && rready) begin
                got = 1'b1;
                rready <= 1'b0;
                check(rdata, exp);
                check(32'(rresp), 32'(er));
            end
        end
    endtask

    task automatic pulse(input int w, input dsh_pkg::dsh_word_type bits);
        @(posedge clock);
        ev[w] <= bits;
        @(posedge clock);
        ev[w] <= 16'h0000;
        repeat (3) @(posedge clock);
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        end_of_test();
    end

    initial begin
        err_total = 0;
        comparisons = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        ev = '{default: 16'h0000};
        {seq_active, seq_dynamic, seq_index} = 6'h00;
        {awaddr, awvalid, wdata, wvalid, bready} = 43'h0;
        wstrb = 4'hF;
        {araddr, arvalid, rready} = 10'h000;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            rd_chk(8'(4 * a), (a == 5) ? 32'h0000_00FF : 32'h0000_0000, `DSH_RESP_OKAY);
        end
        foreach (rows[i]) begin
            pulse(rows[i].w, rows[i].ev);
            rd_chk(8'(4 * rows[i].w), {16'h0000, rows[i].hist}, `DSH_RESP_OKAY);
            wr(8'(4 * rows[i].w), {16'h0000, rows[i].ev}, `DSH_RESP_OKAY);
            rd_chk(8'(4 * rows[i].w), 32'h0000_0000, `DSH_RESP_OKAY);
        end
        foreach (seqs[i]) begin
            @(posedge clock);
            {seq_dynamic, seq_active, seq_index} <= {seqs[i].dyn, seqs[i].act, seqs[i].idx};
            repeat (3) @(posedge clock);
            rd_chk(`DSH_OFF_ACT_SEQ, {24'h00_0000, seqs[i].code}, `DSH_RESP_OKAY);
        end
        @(posedge clock);
        ev[2] <= 16'h0005;
        repeat (3) @(posedge clock);
        rd_chk(`DSH_OFF_STAT1, 32'h0000_0000, `DSH_RESP_OKAY);
        @(posedge clock);
        ev[2] <= 16'h0000;
        repeat (3) @(posedge clock);
        rd_chk(`DSH_OFF_STAT1, 32'h0000_0005, `DSH_RESP_OKAY);
        wr(`DSH_OFF_STAT1, 32'h0000_0001, `DSH_RESP_OKAY);
        rd_chk(`DSH_OFF_STAT1, 32'h0000_0004, `DSH_RESP_OKAY);
        wr(`DSH_OFF_STAT1, 32'h0000_0000, `DSH_RESP_OKAY);
        rd_chk(`DSH_OFF_STAT1, 32'h0000_0004, `DSH_RESP_OKAY);
        // Low byte not strobed: bit 2 must survive
        wstrb <= 4'hE;
        wr(`DSH_OFF_STAT1, 32'h0000_0004, `DSH_RESP_OKAY);
        wstrb <= 4'hF;
        rd_chk(`DSH_OFF_STAT1, 32'h0000_0004, `DSH_RESP_OKAY);
        wr(`DSH_OFF_ACT_SEQ, 32'h0000_FF00, `DSH_RESP_OKAY);
        wr(`DSH_OFF_RSVD_A, 32'hFFFF_FFFF, `DSH_RESP_OKAY);
        wr(`DSH_OFF_RSVD_B, 32'hFFFF_FFFF, `DSH_RESP_OKAY);
        rd_chk(`DSH_OFF_ACT_SEQ, 32'h0000_00FF, `DSH_RESP_OKAY);
        rd_chk(`DSH_OFF_RSVD_A, 32'h0000_0000, `DSH_RESP_OKAY);
        rd_chk(`DSH_OFF_RSVD_B, 32'h0000_0000, `DSH_RESP_OKAY);
        wr(8'h28, 32'hFFFF_FFFF, `DSH_RESP_SLVERR);
        rd_chk(8'h28, 32'h0000_0000, `DSH_RESP_SLVERR);
        // Interrupt: masked source, unmasked source, clear
        rd_chk(`DSH_OFF_IRQ_STATUS, 32'h0000_003F, `DSH_RESP_OKAY);
        wr(`DSH_OFF_IRQ_STATUS, 32'h0000_003F, `DSH_RESP_OKAY);
        wr(`DSH_OFF_IRQ_MASK, 32'h0000_0001, `DSH_RESP_OKAY);
        pulse(1, 16'h0001);
        check(32'(irq), 32'h0000_0000);
        pulse(0, 16'h0001);
        check(32'(irq), 32'h0000_0001);
        rd_chk(`DSH_OFF_IRQ_STATUS, 32'h0000_0003, `DSH_RESP_OKAY);
        wr(`DSH_OFF_IRQ_STATUS, 32'h0000_0001, `DSH_RESP_OKAY);
        repeat (3) @(posedge clock);
        check(32'(irq), 32'h0000_0000);
        rd_chk(`DSH_OFF_IRQ_STATUS, 32'h0000_0002, `DSH_RESP_OKAY);
        // Pulse while frozen is not recorded
        @(posedge clock);
        ce <= 1'b0;
        ev[3] <= 16'h0001;
        @(posedge clock);
        ev[3] <= 16'h0000;
        @(posedge clock);
        ce <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(`DSH_OFF_STAT2, 32'h0000_0000, `DSH_RESP_OKAY);
        // Second reset in mid-run
        pulse(4, 16'h0040);
        rd_chk(`DSH_OFF_STAT3, 32'h0000_0040, `DSH_RESP_OKAY);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(`DSH_OFF_STAT3, 32'h0000_0000, `DSH_RESP_OKAY);
        rd_chk(`DSH_OFF_DRV_PROT, 32'h0000_0000, `DSH_RESP_OKAY);
        check(32'(irq), 32'h0000_0000);
        end_of_test();
    end
endmodule
